// ===== inc/pci_bus_if.sv
`timescale 1ns/1ps
interface pci_bus_if;
  // Master-driven lines, each but req_n with its own enable
  logic req_n;
  logic frame_n;
  logic frame_oe;
  logic irdy_n;
  logic irdy_oe;
  logic [31:0] m_ad;
  logic m_ad_oe;
  logic [3:0] cbe_n;
  logic cbe_oe;
  // Arbiter and target lines
  logic gnt_n;
  logic trdy_n;
  logic stop_n;
  logic devsel_n;
  logic t_oe;
  logic [31:0] t_ad;
  logic t_ad_oe;
  // Resolved bus levels; released lines float high through pull-ups
  logic frame_w;
  logic irdy_w;
  logic trdy_w;
  logic stop_w;
  logic devsel_w;
  logic [31:0] ad_w;
  logic [3:0] cbe_w;
  assign frame_w = frame_oe ? frame_n : 1'b1;
  assign irdy_w = irdy_oe ? irdy_n : 1'b1;
  assign trdy_w = t_oe ? trdy_n : 1'b1;
  assign stop_w = t_oe ? stop_n : 1'b1;
  assign devsel_w = t_oe ? devsel_n : 1'b1;
  assign ad_w = m_ad_oe ? m_ad : (t_ad_oe ? t_ad : 32'hffffffff);
  assign cbe_w = cbe_oe ? cbe_n : 4'hf;
  modport master (
    output req_n, frame_n, frame_oe, irdy_n, irdy_oe, m_ad, m_ad_oe, cbe_n, cbe_oe,
    input gnt_n, frame_w, irdy_w, trdy_w, stop_w, devsel_w, ad_w, cbe_w
  );
  modport target (
    output gnt_n, trdy_n, stop_n, devsel_n, t_oe, t_ad, t_ad_oe,
    input req_n, frame_w, irdy_w, trdy_w, stop_w, devsel_w, ad_w, cbe_w
  );
endinterface

// ===== inc/pci_dma_pkg.sv
package pci_dma_pkg;
  // Register index on the two-bit register port address
  localparam logic [1:0] IDX_PCI_START = 2'h0;
  localparam logic [1:0] IDX_MEM_START = 2'h1;
  localparam logic [1:0] IDX_CONTROL = 2'h2;
  localparam logic [1:0] IDX_STATUS = 2'h3;
  // Control register field positions
  localparam int BIT_DONE = 1;
  localparam int BIT_DIR = 3;
  localparam int BIT_REQ = 4;
  localparam int BIT_EN = 5;
  localparam int LEN_LSB = 16;
  localparam int LEN_MSB = 27;
  // Values after reset
  localparam logic [31:0] ADDR_RESET = 32'h0;
  localparam logic [11:0] LEN_RESET = 12'h000;
  // Length field of zero means the largest transfer
  localparam logic [10:0] LEN_MAX = 11'h400;
  // Bus commands and byte enables
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] BE_ALL = 4'h0;
  // Cycles from start pulse to first frame, and register read latency
  localparam logic [1:0] LEAD_CYCLES = 2'h2;
  localparam int READ_LATENCY = 2;
  // Master sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_REQ = 5'h02,
    ST_LEAD = 5'h04,
    ST_DATA = 5'h08,
    ST_TURN = 5'h10
  } master_state_e;
endpackage

// ===== logic/pci_bus_partner.sv
`timescale 1ns/1ps
// Arbiter plus one memory target; read data is the word's own bus address
module pci_bus_partner (
  input wire logic clk_sys, // 200 MHz clock
  input wire logic rst_n, // Synchronous reset, active low
  pci_bus_if.target bus, // Shared bus
  input wire logic arb_allow, // Arbiter may grant
  input wire logic tgt_ready, // Target may complete data phases
  input wire logic tgt_disconnect, // Target asks to stop the burst
  output logic [31:0] tgt_addr, // Current target word address
  output logic [3:0] tgt_cmd, // Command of current access
  output logic [31:0] tgt_wdata, // Last word transferred, read or write
  output logic tgt_wvalid, // Pulse per written word
  output logic tgt_busy // Target claimed an access
);
  logic gnt_n_reg; // Registered grant
  logic frame_prev_reg; // Frame one cycle ago
  logic active_reg; // Access in progress
  logic release_reg; // Drive lines high one cycle before letting go
  logic trdy_n_reg, stop_n_reg, devsel_n_reg, t_oe_reg;
  logic [31:0] addr_reg, t_ad_reg, wdata_reg;
  logic [3:0] cmd_reg;
  logic t_ad_oe_reg, wvalid_reg;
  logic start, xfer, last;

  assign bus.gnt_n = gnt_n_reg;
  assign bus.trdy_n = trdy_n_reg;
  assign bus.stop_n = stop_n_reg;
  assign bus.devsel_n = devsel_n_reg;
  assign bus.t_oe = t_oe_reg;
  assign bus.t_ad = t_ad_reg;
  assign bus.t_ad_oe = t_ad_oe_reg;
  assign tgt_addr = addr_reg;
  assign tgt_cmd = cmd_reg;
  assign tgt_wdata = wdata_reg;
  assign tgt_wvalid = wvalid_reg;
  assign tgt_busy = active_reg;

  // Falling frame with idle target opens an access
  assign start = !active_reg && frame_prev_reg && !bus.frame_w;
  assign xfer = active_reg && !bus.irdy_w && !trdy_n_reg && !devsel_n_reg;
  // Final phase: frame already high and the phase completes or is stopped
  assign last = active_reg && bus.frame_w && !bus.irdy_w && (xfer || !stop_n_reg);

  // Grant follows the request while the arbiter allows it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gnt_n_reg <= 1'b1;
      frame_prev_reg <= 1'b1;
    end else begin
      gnt_n_reg <= !(!bus.req_n && arb_allow);
      frame_prev_reg <= bus.frame_w;
    end
  end

  // Target handshake lines
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
      release_reg <= 1'b0;
      trdy_n_reg <= 1'b1;
      stop_n_reg <= 1'b1;
      devsel_n_reg <= 1'b1;
      t_oe_reg <= 1'b0;
    end else if (start) begin
      // Claim now, first data phase one cycle later
      active_reg <= 1'b1;
      devsel_n_reg <= 1'b0;
      t_oe_reg <= 1'b1;
    end else if (last) begin
      active_reg <= 1'b0;
      release_reg <= 1'b1;
      trdy_n_reg <= 1'b1;
      stop_n_reg <= 1'b1;
      devsel_n_reg <= 1'b1;
    end else if (active_reg) begin
      trdy_n_reg <= !tgt_ready;
      stop_n_reg <= !tgt_disconnect;
    end else if (release_reg) begin
      release_reg <= 1'b0;
      t_oe_reg <= 1'b0;
    end
  end

  // Address, command and data
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addr_reg <= pci_dma_pkg::ADDR_RESET;
      cmd_reg <= 4'h0;
      t_ad_reg <= pci_dma_pkg::ADDR_RESET;
      t_ad_oe_reg <= 1'b0;
      wdata_reg <= 32'h0;
      wvalid_reg <= 1'b0;
    end else begin
      wvalid_reg <= xfer && (cmd_reg == pci_dma_pkg::CMD_MEM_WRITE);
      if (start) begin
        addr_reg <= bus.ad_w;
        cmd_reg <= bus.cbe_w;
        t_ad_reg <= bus.ad_w;
      end else if (xfer) begin
        addr_reg <= addr_reg + 32'h4;
        t_ad_reg <= addr_reg + 32'h4;
        wdata_reg <= bus.ad_w;
      end
      // Read data starts after the address turnaround
      t_ad_oe_reg <= active_reg && !last && (cmd_reg == pci_dma_pkg::CMD_MEM_READ);
    end
  end
endmodule

// ===== logic/pci_dma_master.sv
`timescale 1ns/1ps
// Overview of operation
// - Software loads both start addresses first
// - Control bit 3 picks transfer direction
// - Length bits 27-16; zero means 1024
// - Start needs request and enable bits
// - Completion sets control bit 1
// - Read: arbitrate, frame, address, command 0110
// - Read: irdy, wait trdy, burst to length
// - Grant pulses start; address with frame
// - Two-word buffer; stop backend strobe when full
// - Burst ends on count or disconnect
// - Write: irdy only once pipe holds data
// - Zero-wait and paced bursts both work
// - Pause input halts; resume on release
// - Backend cancels by clearing request bit
// - Frame two cycles after start, unless stalled
// - No irdy before backend read ready
// - Slow backend holds stall until ready; a stall past lead count 1 holds ST_LEAD until the grant is lost
// - Stall keeps bus idle; lost grant aborts
// - Select plus write strobe writes each cycle
// - Reads two cycles late, gated output
// - Port: select, read, write strobes, 2-bit address
// - Ready may lead data by one cycle
// - Local bus granted at idle, held
module pci_dma_master #(
  parameter int DW = 32, // Data width
  parameter int DEPTH = 2 // Buffered words
) (
  input wire logic clk_sys, // 200 MHz clock
  input wire logic rst_n, // Synchronous reset, active low
  pci_bus_if.master bus, // Shared bus
  input wire logic reg_port_select_n, // Register select
  input wire logic reg_port_read_n, // Register read strobe
  input wire logic reg_port_write_n, // Register write strobe
  input wire logic [1:0] reg_port_addr, // Register index
  input wire logic [31:0] reg_port_wdata, // Register write data
  output logic [31:0] reg_port_rdata, // Register read data
  output logic reg_port_rdata_oe, // Read data drive enable
  input wire logic local_bus_request, // Backend wants the local bus
  output logic local_bus_grant, // Local bus granted
  input wire logic stall_master, // Hold off frame
  input wire logic busy_master, // Pause transfer
  output logic datapath_begin_pulse, // Pulse on bus grant
  output logic datapath_abort_pulse, // Pulse when grant lost early
  output logic datapath_finished, // Pulse on completion
  output logic local_read_cycle, // Backend fetch phase active
  input wire logic backend_read_ready, // Backend can supply words
  output logic backend_read_strobe, // Word taken from mem_rdata
  input wire logic [DW-1:0] mem_rdata, // Backend supplied word
  input wire logic backend_write_ready, // Backend can accept words
  output logic backend_write_strobe, // Word valid on mem_wdata
  output logic [DW-1:0] mem_wdata, // Word to backend
  output logic [31:0] mem_address // Backend word address
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  pci_dma_pkg::master_state_e state_reg;
  // Registers
  logic [31:0] pci_start_reg, mem_start_reg;
  logic [11:0] len_reg;
  logic dir_reg, req_reg, en_reg, done_reg;
  // Working counters
  logic [10:0] left_reg, fetch_left_reg;
  logic [31:0] pci_cur_reg, mem_cur_reg;
  logic [1:0] lead_cnt_reg;
  // Two-word buffer
  logic [DW-1:0] fifo_mem [DEPTH];
  logic [PW-1:0] rd_ptr_reg, wr_ptr_reg;
  logic [PW:0] cnt_reg, cnt_next;
  logic [DW-1:0] push_data, head_after;
  // Bus output registers
  logic req_n_reg, frame_n_reg, frame_oe_reg, irdy_n_reg, irdy_oe_reg;
  logic [31:0] ad_reg;
  logic ad_oe_reg, cbe_oe_reg;
  logic [3:0] cbe_reg;
  // Backend side registers
  logic grant_reg, begin_reg, abort_reg, fin_reg, rcyc_reg;
  logic rstrobe_reg, wstrobe_reg;
  logic [DW-1:0] wdata_reg;
  logic [31:0] maddr_reg;
  logic [1:0] rd_idx_reg;
  logic [31:0] rdata_reg;
  logic rdata_oe_reg;
  // Decode
  logic reg_wr, start_ok, lost, go, xfer, fin, drain, push, pop;
  logic irdy_go, end_req, fetch_go, set_done;
  logic [10:0] left_after, len_words;

  assign bus.req_n = req_n_reg;
  assign bus.frame_n = frame_n_reg;
  assign bus.frame_oe = frame_oe_reg;
  assign bus.irdy_n = irdy_n_reg;
  assign bus.irdy_oe = irdy_oe_reg;
  assign bus.m_ad = ad_reg;
  assign bus.m_ad_oe = ad_oe_reg;
  assign bus.cbe_n = cbe_reg;
  assign bus.cbe_oe = cbe_oe_reg;
  assign reg_port_rdata = rdata_reg;
  assign reg_port_rdata_oe = rdata_oe_reg;
  assign local_bus_grant = grant_reg;
  assign datapath_begin_pulse = begin_reg;
  assign datapath_abort_pulse = abort_reg;
  assign datapath_finished = fin_reg;
  assign local_read_cycle = rcyc_reg;
  assign backend_read_strobe = rstrobe_reg;
  assign backend_write_strobe = wstrobe_reg;
  assign mem_wdata = wdata_reg;
  assign mem_address = maddr_reg;

  // Transfer decisions for this cycle
  always_comb begin
    reg_wr = !reg_port_select_n && !reg_port_write_n;
    len_words = (len_reg == 12'h000) ? pci_dma_pkg::LEN_MAX : len_reg[10:0];
    // No start while paused or while the backend owns the local bus
    start_ok = req_reg && en_reg && !busy_master && !grant_reg && !local_bus_request;
    lost = (state_reg == pci_dma_pkg::ST_LEAD) && bus.gnt_n;
    go = (state_reg == pci_dma_pkg::ST_LEAD) && !bus.gnt_n && !stall_master
      && (lead_cnt_reg == pci_dma_pkg::LEAD_CYCLES - 2'h1);
    xfer = (state_reg == pci_dma_pkg::ST_DATA) && !irdy_n_reg && !bus.trdy_w
      && !bus.devsel_w;
    fin = (state_reg == pci_dma_pkg::ST_DATA) && frame_n_reg && !irdy_n_reg
      && (xfer || !bus.stop_w);
    drain = !dir_reg && (cnt_reg != '0) && backend_write_ready;
    push = dir_reg ? rstrobe_reg : xfer;
    pop = dir_reg ? xfer : drain;
    push_data = dir_reg ? mem_rdata : bus.ad_w;
    cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    if (pop) begin
      head_after = (cnt_reg > (PW+1)'(1)) ? fifo_mem[rd_ptr_reg + PW'(1)] : push_data;
    end else begin
      head_after = (cnt_reg != '0) ? fifo_mem[rd_ptr_reg] : push_data;
    end
    left_after = left_reg - 11'(xfer);
    // Read needs room for the next word, write needs a buffered word
    irdy_go = (left_after != 11'h0) && (dir_reg ? (cnt_next != '0) : (cnt_next < FULL));
    end_req = (left_after <= 11'h1) || !bus.stop_w || busy_master;
    // Fetch only while room remains for the word already in flight
    fetch_go = dir_reg && backend_read_ready && (fetch_left_reg != 11'h0)
      && (cnt_next < FULL) && ((state_reg == pci_dma_pkg::ST_LEAD)
      || (state_reg == pci_dma_pkg::ST_DATA));
    set_done = (state_reg == pci_dma_pkg::ST_TURN) && (left_reg == 11'h0);
  end

  // Sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= pci_dma_pkg::ST_IDLE;
      lead_cnt_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        pci_dma_pkg::ST_IDLE: if (start_ok) state_reg <= pci_dma_pkg::ST_REQ;
        pci_dma_pkg::ST_REQ: begin
          lead_cnt_reg <= 2'h0;
          if (!bus.gnt_n) state_reg <= pci_dma_pkg::ST_LEAD;
        end
        pci_dma_pkg::ST_LEAD: begin
          // Counter saturates at 3; go needs a count of 1, so a stall past it holds ST_LEAD until the grant is lost
          if (lead_cnt_reg != 2'h3) lead_cnt_reg <= lead_cnt_reg + 2'h1;
          if (lost) state_reg <= pci_dma_pkg::ST_IDLE;
          else if (go) state_reg <= pci_dma_pkg::ST_DATA;
        end
        pci_dma_pkg::ST_DATA: if (fin) state_reg <= pci_dma_pkg::ST_TURN;
        pci_dma_pkg::ST_TURN: state_reg <= pci_dma_pkg::ST_IDLE;
      endcase
    end
  end

  // Bus drivers; frame and irdy are driven high before release, ad and cbe are released at once
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      req_n_reg <= 1'b1;
      frame_n_reg <= 1'b1;
      frame_oe_reg <= 1'b0;
      irdy_n_reg <= 1'b1;
      irdy_oe_reg <= 1'b0;
      ad_reg <= pci_dma_pkg::ADDR_RESET;
      ad_oe_reg <= 1'b0;
      cbe_reg <= pci_dma_pkg::BE_ALL;
      cbe_oe_reg <= 1'b0;
    end else begin
      req_n_reg <= !((state_reg == pci_dma_pkg::ST_IDLE && start_ok)
        || state_reg == pci_dma_pkg::ST_REQ
        || (state_reg == pci_dma_pkg::ST_LEAD && !go && !lost));
      if (go) begin
        // Address and command appear with the first low frame
        frame_n_reg <= 1'b0;
        frame_oe_reg <= 1'b1;
        ad_reg <= pci_cur_reg;
        ad_oe_reg <= 1'b1;
        cbe_reg <= dir_reg ? pci_dma_pkg::CMD_MEM_WRITE : pci_dma_pkg::CMD_MEM_READ;
        cbe_oe_reg <= 1'b1;
        irdy_oe_reg <= 1'b1;
      end else if (state_reg == pci_dma_pkg::ST_DATA) begin
        if (fin) begin
          frame_oe_reg <= 1'b0;
          irdy_n_reg <= 1'b1;
          ad_oe_reg <= 1'b0;
          cbe_oe_reg <= 1'b0;
        end else begin
          irdy_n_reg <= !irdy_go;
          if (irdy_go && end_req) frame_n_reg <= 1'b1;
          cbe_reg <= pci_dma_pkg::BE_ALL;
          ad_oe_reg <= dir_reg;
          if (dir_reg && cnt_next != '0) ad_reg <= head_after;
        end
      end else if (state_reg == pci_dma_pkg::ST_TURN) begin
        irdy_oe_reg <= 1'b0;
      end
    end
  end

  // Two-entry buffer between bus and backend
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (state_reg == pci_dma_pkg::ST_IDLE && !req_reg)) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr_reg] <= push_data;
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      end
      if (pop) rd_ptr_reg <= rd_ptr_reg + PW'(1);
      cnt_reg <= cnt_next;
    end
  end

  // Working addresses and counts; resume keeps them, cancel clears the counts
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      left_reg <= 11'h0;
      fetch_left_reg <= 11'h0;
      pci_cur_reg <= pci_dma_pkg::ADDR_RESET;
      mem_cur_reg <= pci_dma_pkg::ADDR_RESET;
    end else if (state_reg == pci_dma_pkg::ST_IDLE && !req_reg) begin
      left_reg <= 11'h0;
      fetch_left_reg <= 11'h0;
    end else if (state_reg == pci_dma_pkg::ST_IDLE && start_ok && left_reg == 11'h0) begin
      left_reg <= len_words;
      fetch_left_reg <= len_words;
      pci_cur_reg <= pci_start_reg;
      mem_cur_reg <= mem_start_reg;
    end else begin
      left_reg <= left_after;
      if (xfer) pci_cur_reg <= pci_cur_reg + 32'h4;
      if (fetch_go) fetch_left_reg <= fetch_left_reg - 11'h1;
      if (fetch_go || drain) mem_cur_reg <= mem_cur_reg + 32'h4;
    end
  end

  // Backend strobes, address, pulses and local bus grant
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rstrobe_reg <= 1'b0;
      wstrobe_reg <= 1'b0;
      wdata_reg <= '0;
      maddr_reg <= pci_dma_pkg::ADDR_RESET;
      begin_reg <= 1'b0;
      abort_reg <= 1'b0;
      fin_reg <= 1'b0;
      rcyc_reg <= 1'b0;
      grant_reg <= 1'b0;
    end else begin
      rstrobe_reg <= fetch_go;
      wstrobe_reg <= drain;
      if (drain) wdata_reg <= fifo_mem[rd_ptr_reg];
      if (fetch_go || drain) maddr_reg <= mem_cur_reg;
      begin_reg <= (state_reg == pci_dma_pkg::ST_REQ) && !bus.gnt_n;
      abort_reg <= lost;
      fin_reg <= set_done;
      rcyc_reg <= dir_reg && (state_reg == pci_dma_pkg::ST_LEAD
        || state_reg == pci_dma_pkg::ST_DATA);
      grant_reg <= local_bus_request && (grant_reg || state_reg == pci_dma_pkg::ST_IDLE);
    end
  end

  // Register writes; hardware completion wins over software
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pci_start_reg <= pci_dma_pkg::ADDR_RESET;
      mem_start_reg <= pci_dma_pkg::ADDR_RESET;
      len_reg <= pci_dma_pkg::LEN_RESET;
      dir_reg <= 1'b0;
      req_reg <= 1'b0;
      en_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_port_addr == pci_dma_pkg::IDX_PCI_START) pci_start_reg <= reg_port_wdata;
      if (reg_wr && reg_port_addr == pci_dma_pkg::IDX_MEM_START) mem_start_reg <= reg_port_wdata;
      if (reg_wr && reg_port_addr == pci_dma_pkg::IDX_CONTROL) begin
        len_reg <= reg_port_wdata[pci_dma_pkg::LEN_MSB:pci_dma_pkg::LEN_LSB];
        dir_reg <= reg_port_wdata[pci_dma_pkg::BIT_DIR];
        en_reg <= reg_port_wdata[pci_dma_pkg::BIT_EN];
        req_reg <= reg_port_wdata[pci_dma_pkg::BIT_REQ] && !set_done;
        done_reg <= reg_port_wdata[pci_dma_pkg::BIT_DONE] || set_done;
      end else if (set_done) begin
        done_reg <= 1'b1;
        req_reg <= 1'b0;
      end
    end
  end

  // Pipelined register read: data two cycles after the address
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_idx_reg <= 2'h0;
      rdata_reg <= 32'h0;
      rdata_oe_reg <= 1'b0;
    end else begin
      rd_idx_reg <= reg_port_addr;
      rdata_oe_reg <= !reg_port_select_n && !reg_port_read_n;
      unique case (rd_idx_reg)
        pci_dma_pkg::IDX_PCI_START: rdata_reg <= pci_start_reg;
        pci_dma_pkg::IDX_MEM_START: rdata_reg <= mem_start_reg;
        pci_dma_pkg::IDX_CONTROL: rdata_reg <= {4'h0, len_reg, 10'h0, en_reg, req_reg,
          dir_reg, 1'b0, done_reg, 1'b0};
        pci_dma_pkg::IDX_STATUS: rdata_reg <= {11'h0, state_reg, 5'h0, left_reg};
      endcase
    end
  end
endmodule

// ===== test/pci_dma_master_tb.sv
`timescale 1ns/1ps
module pci_dma_master_tb;
  logic clk_sys = 0, rst_n = 0; // Clock and reset
  logic sel_n = 1, rd_n = 1, wr_n = 1, lbr = 0, stall = 0, busy = 0; // Backend controls
  logic [1:0] ra = 2'h0; // Register index
  logic [31:0] wd = 32'h0, rdat, mwd, madr, twd, mrd = 32'h0; // Data paths
  logic rdoe, lbg, bp, ab, fin, lrc, brs, bws, tw; // Design outputs
  logic allow = 1, tready = 1, tdisc = 0; // Far-end controls
  logic fprev = 1; // Previous frame level
  int failures = 0, num_checks = 0, nf = 0, fin_cnt = 0, bp_cnt = 0, ab_cnt = 0, bstr = 0;
  logic [31:0] bq[$], baq[$], tq[$]; // Words seen at backend and target
  pci_bus_if pbus();
  pci_dma_master i_pci_dma_master (.clk_sys(clk_sys), .rst_n(rst_n), .bus(pbus),
    .reg_port_select_n(sel_n), .reg_port_read_n(rd_n), .reg_port_write_n(wr_n),
    .reg_port_addr(ra), .reg_port_wdata(wd), .reg_port_rdata(rdat), .reg_port_rdata_oe(rdoe),
    .local_bus_request(lbr), .local_bus_grant(lbg), .stall_master(stall), .busy_master(busy),
    .datapath_begin_pulse(bp), .datapath_abort_pulse(ab), .datapath_finished(fin),
    .local_read_cycle(lrc), .backend_read_ready(1'b1), .backend_read_strobe(brs),
    .mem_rdata(mrd), .backend_write_ready(1'b1), .backend_write_strobe(bws),
    .mem_wdata(mwd), .mem_address(madr));
  pci_bus_partner i_pci_bus_partner (.clk_sys(clk_sys), .rst_n(rst_n), .bus(pbus),
    .arb_allow(allow), .tgt_ready(tready), .tgt_disconnect(tdisc), .tgt_addr(),
    .tgt_cmd(), .tgt_wdata(twd), .tgt_wvalid(tw), .tgt_busy());
  pci_dma_properties i_pci_dma_properties (.clk_sys(clk_sys), .rst_n(rst_n),
    .gnt_n(pbus.gnt_n), .frame_w(pbus.frame_w), .irdy_w(pbus.irdy_w), .trdy_w(pbus.trdy_w),
    .stop_w(pbus.stop_w), .cbe_w(pbus.cbe_w));
  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;
  // Event counters and word capture; backend data steps once per word taken
  always @(posedge clk_sys) begin
    fprev <= pbus.frame_w;
    if (fprev && !pbus.frame_w) nf++;
    if (fin) fin_cnt++;
    if (bp) bp_cnt++;
    if (ab) ab_cnt++;
    if (brs) begin
      bstr++;
      mrd <= mrd + 32'h1;
    end
    if (bws) begin
      bq.push_back(mwd);
      baq.push_back(madr);
    end
    if (tw) tq.push_back(twd);
  end
  // Control word: length, enable set, request and direction chosen
  function automatic logic [31:0] cw(input logic [11:0] n, input logic d, input logic r);
    cw = {4'h0, n, 10'h0, 1'b1, r, d, 3'h0};
  endfunction
  // Shared comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One register write
  task automatic wr1(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_sys) {sel_n, wr_n, ra, wd} <= {2'b00, a, d};
    @(posedge clk_sys) {sel_n, wr_n} <= 2'b11;
  endtask
  // Burst write of both start addresses then control, strobes held low
  task automatic go(input logic [31:0] p, input logic [31:0] m, input logic [31:0] c);
    @(posedge clk_sys) {sel_n, wr_n, ra, wd} <= {2'b00, 2'h0, p};
    @(posedge clk_sys) {ra, wd} <= {2'h1, m};
    @(posedge clk_sys) {ra, wd} <= {2'h2, c};
    @(posedge clk_sys) {sel_n, wr_n} <= 2'b11;
  endtask
  // Pipelined read compared after two cycles
  task automatic rd(input logic [1:0] a, input logic [31:0] e);
    @(posedge clk_sys) {sel_n, rd_n, ra} <= {2'b00, a};
    repeat (2) @(posedge clk_sys);
    #1 chk("rdata", e, rdat);
    chk("rdata_oe", 1, rdoe);
    @(posedge clk_sys) {sel_n, rd_n} <= 2'b11;
  endtask
  task automatic wait_fin(input int n);
    for (int i = 0; i < 8000 && fin_cnt < n; i++) @(posedge clk_sys);
    chk("finished", n, fin_cnt);
  endtask
  // Registers hold values; no start without request bit
  task automatic t_regs();
    rd(2'h2, 32'h0);
    go(32'h1000, 32'h2000, cw(12'h5, 0, 0));
    repeat (20) @(posedge clk_sys);
    chk("no frame", 0, nf);
    rd(2'h0, 32'h1000);
    rd(2'h1, 32'h2000);
    rd(2'h2, cw(12'h5, 0, 0));
  endtask
  // Read from bus into backend, data is the bus address
  task automatic t_read();
    go(32'h1000, 32'h2000, cw(12'h3, 0, 1));
    wait_fin(1);
    repeat (10) @(posedge clk_sys);
    chk("words", 3, bq.size());
    for (int i = 0; i < 3; i++) begin
      chk("bdata", 32'h1000 + 4 * i, bq[i]);
      chk("baddr", 32'h2000 + 4 * i, baq[i]);
    end
    rd(2'h2, cw(12'h3, 0, 0) | 32'h2);
  endtask
  // Write to bus with a slow target: backend fetch stops at two words
  task automatic t_write();
    int b0;
    tready <= 0;
    mrd <= 32'ha000;
    go(32'h3000, 32'h4000, cw(12'h4, 1, 1));
    b0 = bstr;
    repeat (40) @(posedge clk_sys);
    chk("fetch held", 1, (bstr - b0) <= 2);
    chk("read cycle", 1, lrc);
    tready <= 1;
    wait_fin(2);
    chk("twords", 4, tq.size());
    for (int i = 0; i < 4; i++) chk("tdata", 32'ha000 + i, tq[i]);
  endtask
  // Full-length read with a disconnect and a pause
  task automatic t_long();
    int k;
    bq.delete();
    baq.delete();
    go(32'h8000, 32'h0, cw(12'h0, 0, 1));
    for (int i = 0; i < 3000 && bq.size() < 100; i++) @(posedge clk_sys);
    tdisc <= 1;
    @(posedge clk_sys) tdisc <= 0;
    repeat (20) @(posedge clk_sys) busy <= 1;
    k = bq.size();
    repeat (30) @(posedge clk_sys);
    chk("paused", k, bq.size());
    busy <= 0;
    wait_fin(3);
    repeat (10) @(posedge clk_sys);
    chk("words 1024", 1024, bq.size());
    chk("last data", 32'h8000 + 4 * 1023, bq[1023]);
  endtask
  // Pause, take the local bus and clear the request
  task automatic t_cancel();
    int f;
    bq.delete();
    go(32'h1000, 32'h2000, cw(12'h64, 0, 1));
    for (int i = 0; i < 500 && bq.size() < 10; i++) @(posedge clk_sys);
    {busy, lbr} <= 2'b11;
    for (int i = 0; i < 100 && lbg !== 1'b1; i++) @(posedge clk_sys);
    chk("grant", 1, lbg);
    wr1(2'h2, cw(12'h64, 0, 0));
    repeat (3) @(posedge clk_sys);
    chk("grant held", 1, lbg);
    {busy, lbr} <= 2'b00;
    f = nf;
    repeat (300) @(posedge clk_sys);
    chk("cancelled", 3, fin_cnt);
    chk("no frame", f, nf);
  endtask
  // Stall holds the bus idle; losing the grant aborts
  task automatic t_stall();
    int f, b;
    stall <= 1;
    f = nf;
    b = bp_cnt;
    go(32'h1000, 32'h2000, cw(12'h4, 0, 1));
    for (int i = 0; i < 100 && bp_cnt == b; i++) @(posedge clk_sys);
    repeat (10) @(posedge clk_sys);
    chk("begin", b + 1, bp_cnt);
    chk("stalled", f, nf);
    allow <= 0;
    for (int i = 0; i < 100 && ab_cnt == 0; i++) @(posedge clk_sys);
    chk("abort", 1, ab_cnt);
    chk("idle bus", f, nf);
    wr1(2'h2, cw(12'h4, 0, 0));
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence after an eight-cycle reset
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1;
    t_regs();
    t_read();
    t_write();
    t_long();
    t_cancel();
    t_stall();
    report_and_stop();
  end
  // Hang guard, well beyond the expected run
  initial begin
    #400000;
    failures++;
    report_and_stop();
  end
endmodule

// ===== test/pci_dma_properties.sv
`timescale 1ns/1ps
// Bus-level checks on the resolved lines between the two ends
module pci_dma_properties (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic gnt_n, // Arbiter grant
  input wire logic frame_w, // Resolved frame
  input wire logic irdy_w, // Resolved initiator ready
  input wire logic trdy_w, // Resolved target ready
  input wire logic stop_w, // Resolved stop
  input wire logic [3:0] cbe_w // Resolved command and enables
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Address phase always names a memory command
  a_frame_cmd: assert property ($fell(frame_w) |-> cbe_w inside {4'h6, 4'h7})
    else $error("address phase without memory command");
  // Frame only falls while the grant is held
  a_frame_gnt: assert property ($fell(frame_w) |-> !$past(gnt_n))
    else $error("frame started without grant");
  // Initiator ready must follow frame within the bus limit
  a_irdy_limit: assert property ($fell(frame_w) |-> ##[1:8] !irdy_w)
    else $error("irdy late after frame");
  // Frame stays low until a phase with irdy asserted
  a_frame_hold: assert property (!frame_w && irdy_w && stop_w |=> !frame_w || !irdy_w)
    else $error("frame released before data phase");
  // Frame rises only in the last data phase
  a_last_phase: assert property ($rose(frame_w) |-> !irdy_w)
    else $error("frame rose without irdy");
  // Irdy held until the target completes the phase
  a_irdy_wait: assert property (!irdy_w && trdy_w && stop_w |=> !irdy_w)
    else $error("irdy dropped before trdy");
  // Final phase completes and irdy is released
  a_irdy_release: assert property (!irdy_w && frame_w && !trdy_w |=> irdy_w)
    else $error("irdy held after last phase");
  // Irdy released mid-burst only after a completed phase (paced burst)
  a_turn_order: assert property ($rose(irdy_w) |-> frame_w || !$past(trdy_w))
    else $error("irdy released while frame low");
  // Data phases carry all byte lanes
  a_data_lanes: assert property (!irdy_w |-> cbe_w == 4'h0)
    else $error("byte enables not all active");
endmodule
